// ---- src/ussu_core.v ----
// Universal serial shift unit: shift register, counter, flags, pins
`timescale 1ns/100ps
`include "ussu_map.vh"
module ussu_core (
	// Clock and reset
	input  wire       mclk_i,
	input  wire       rst_i,
	// Control write: wire mode, clock select, strobes
	input  wire       ctrl_wr_i,
	input  wire [7:0] ctrl_wdata_i,
	// Shift register write and read
	input  wire       data_wr_i,
	input  wire [7:0] data_wdata_i,
	output wire [7:0] shift_register_o,
	// Status write: flag clears and counter load
	input  wire       status_wr_i,
	input  wire [7:0] status_wdata_i,
	// Port bit of the clock pin
	input  wire       clk_port_wr_i,
	input  wire       clk_port_wdata_i,
	// Pin direction bits
	input  wire       data_out_dir_i,
	input  wire       serial_in_dir_i,
	input  wire       clock_dir_i,
	// Timer compare match, same clock domain
	input  wire       timer_match_i,
	// Pins from outside
	input  wire       serial_in_pin_i,
	input  wire       serial_clock_pin_i,
	// Data output pin (three-wire)
	output wire       data_out_o,
	output wire       data_out_oe_o,
	// Data line drive (two-wire, open drain)
	output wire       sda_o,
	output wire       sda_oe_o,
	// Clock pin drive
	output wire       serial_clock_pin_o,
	output wire       serial_clock_pin_oe_o,
	// Status
	output wire [3:0] counter_o,
	output wire       counter_overflow_flag_o,
	output wire       start_detect_flag_o,
	output wire [1:0] wire_mode_o,
	output wire       idle_wake_o
);
	////////////////////////////////////////////////////////////////////
	// Stored control fields
	reg  [1:0] wire_mode_q;
	reg        external_clock_select_q;
	reg        clock_edge_select_q;
	reg        software_shift_strobe_q;
	reg        clock_port_q;
	reg  [7:0] shift_register_q;
	reg  [7:0] shift_register_d;
	reg  [3:0] counter_q;
	reg  [3:0] counter_d;
	reg        counter_overflow_flag_q;
	reg        start_detect_flag_q;
	reg        start_hold_q;
	reg        sample_bit_q;

	// Synchronised pin views
	wire       sck_lvl;
	wire       sck_rise;
	wire       sck_fall;
	wire       din_lvl;
	wire       din_rise;
	wire       din_fall;

	// Decoded strobes of this cycle's control write
	wire       toggle_stb;
	wire       shift_stb;
	wire       cs1_now;
	wire       cs0_now;
	wire       clk_now;
	wire [1:0] wm_now;

	// Derived events
	wire       two_wire;
	wire       three_wire;
	wire       sample_edge;
	wire       output_edge;
	wire       shift_evt;
	wire       count_evt;
	wire       wrap_evt;
	wire       start_evt;
	wire       sck_any_evt;
	wire       ovf_clr;
	wire       sif_clr;
	wire       ovf_hold;
	wire       latch_open;
	wire       latch_bit;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; both pins come from outside this clock
	// The two flops cost one to two system clocks of latency, so the
	// link clock needs half periods of at least three system clocks;
	// shorter pulses can slip between samples and lose a count.
	ussu_pin_sync u_sck_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (serial_clock_pin_i),
		.level_o (sck_lvl),
		.rise_o  (sck_rise),
		.fall_o  (sck_fall)
	);

	ussu_pin_sync u_din_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (serial_in_pin_i),
		.level_o (din_lvl),
		.rise_o  (din_rise),
		.fall_o  (din_fall)
	);

	////////////////////////////////////////////////////////////////////
	// Control write decode; strobes act in the cycle of the write
	assign wm_now   = ctrl_wdata_i[`USSU_CR_WM_HI:`USSU_CR_WM_LO];
	assign cs1_now  = ctrl_wdata_i[`USSU_CR_CS1];
	assign cs0_now  = ctrl_wdata_i[`USSU_CR_CS0];
	assign clk_now  = ctrl_wdata_i[`USSU_CR_CLK];
	assign toggle_stb = ctrl_wr_i & ctrl_wdata_i[`USSU_CR_TC];
	assign shift_stb  = ctrl_wr_i & clk_now;

	// Mode fields hold until the next control write
	// The software shift bit is kept too, since the counter source
	// depends on it long after the write that set it.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			wire_mode_q             <= `USSU_WM_OFF;
			external_clock_select_q <= 1'b0;
			clock_edge_select_q     <= 1'b0;
			software_shift_strobe_q <= 1'b0;
		end else if (ctrl_wr_i) begin
			wire_mode_q             <= wm_now;
			external_clock_select_q <= cs1_now;
			clock_edge_select_q     <= cs0_now;
			software_shift_strobe_q <= clk_now;
		end
	end

	assign two_wire   = wire_mode_q[1];
	assign three_wire = (wire_mode_q == `USSU_WM_THREE);

	////////////////////////////////////////////////////////////////////
	// Clock pin port bit: port write loads it, toggle strobe flips it
	// Toggle beats a port write in the same cycle; both are software
	always @(posedge mclk_i) begin
		if (rst_i) begin
			clock_port_q <= 1'b0;
		end else if (toggle_stb) begin
			clock_port_q <= ~clock_port_q;
		end else if (clk_port_wr_i) begin
			clock_port_q <= clk_port_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Edge choice on the external clock; edge select swaps them
	assign sample_edge = clock_edge_select_q ? sck_fall
	                                         : sck_rise;
	assign output_edge = clock_edge_select_q ? sck_rise
	                                         : sck_fall;

	// Shift source: external sampling edge, timer match or strobe.
	// The strobe in a mode write counts with the mode stored before it, as
	// the fast master loop alternates writes with and without it.
	// Timer mode needs the edge select bit with the external clock off.
	assign shift_evt = external_clock_select_q ? sample_edge
	                 : clock_edge_select_q ? timer_match_i
	                 : shift_stb;

	// Counter source: both external edges, or the toggle strobe when
	// the software shift bit is set with the external clock; without
	// the external clock it counts the shift source.
	assign count_evt = external_clock_select_q
	                 ? (software_shift_strobe_q ? toggle_stb
	                                            : (sck_rise | sck_fall))
	                 : shift_evt;

	assign wrap_evt = count_evt & (counter_q == `USSU_CNT_MAX);

	////////////////////////////////////////////////////////////////////
	// Sampled input bit, a copy of the synchronised level taken every system clock
	// A registered copy keeps internal shifts off the synchroniser edge
	always @(posedge mclk_i) begin
		if (rst_i) begin
			sample_bit_q <= 1'b0;
		end else begin
			sample_bit_q <= din_lvl;
		end
	end

	// Shift register next value. A write in the same cycle wins and
	// suppresses the shift, so software never sees a mixed byte.
	always @* begin
		shift_register_d = shift_register_q;
		if (data_wr_i) begin
			shift_register_d = data_wdata_i;
		end else if (shift_evt) begin
			// Internal clocks take the registered copy; external edges use the
			// synchronised level that made the edge
			shift_register_d = {shift_register_q[6:0],
			                    external_clock_select_q ? din_lvl
			                                            : sample_bit_q};
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			shift_register_q <= `USSU_DATA_RST;
		end else begin
			shift_register_q <= shift_register_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter: a status write loads it, otherwise it counts events.
	// Overflow is a wrap from 15 back to 0.
	// A status write always reloads the counter, so an edge in the same
	// cycle is not counted; the wrap flag still sets, so a finished
	// byte is never lost to a late clear.
	always @* begin
		counter_d = counter_q;
		if (status_wr_i) begin
			counter_d = status_wdata_i[`USSU_SR_CNT_HI:0];
		end else if (count_evt) begin
			counter_d = counter_q + 4'h1;
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			counter_q <= `USSU_CNT_RST;
		end else begin
			counter_q <= counter_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flag clears by writing one; a set in the same cycle wins
	assign ovf_clr = status_wr_i & status_wdata_i[`USSU_SR_OIF];
	assign sif_clr = status_wr_i & status_wdata_i[`USSU_SR_SIF];

	always @(posedge mclk_i) begin
		if (rst_i) begin
			counter_overflow_flag_q <= 1'b0;
		end else if (wrap_evt) begin
			counter_overflow_flag_q <= 1'b1;
		end else if (ovf_clr) begin
			counter_overflow_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Start detection: in two-wire mode a data fall with the clock
	// high; in three-wire mode with an external clock and no software
	// shift bit, any clock edge sets the flag as well.
	assign sck_any_evt = three_wire & external_clock_select_q
	                   & ~software_shift_strobe_q & (sck_rise | sck_fall);
	assign start_evt   = (two_wire & din_fall & sck_lvl)
	                   | sck_any_evt;

	always @(posedge mclk_i) begin
		if (rst_i) begin
			start_detect_flag_q <= 1'b0;
		end else if (start_evt) begin
			start_detect_flag_q <= 1'b1;
		end else if (sif_clr) begin
			start_detect_flag_q <= 1'b0;
		end
	end

	// Start hold grabs the clock once the master has pulled it low
	// after a start and keeps it until the flag is cleared
	// Without it a fast master could clock the first address bit
	// before software has cleared the flag and the counter.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			start_hold_q <= 1'b0;
		end else if (!two_wire || sif_clr) begin
			start_hold_q <= 1'b0;
		end else if (start_detect_flag_q && !sck_lvl) begin
			start_hold_q <= 1'b1;
		end
	end

	// Overflow hold only in the two-wire mode that asks for it
	assign ovf_hold = (wire_mode_q == `USSU_WM_TWO_OVH)
	                & counter_overflow_flag_q;

	////////////////////////////////////////////////////////////////////
	// Output latch: with an external clock it is open in the first
	// half of a clock cycle, the phase before the sampling edge, so
	// output and sampling happen on opposite edges.
	// The latch is a flop fed by the next register value, so a fresh
	// MSB reaches the pin in the cycle after it is written.
	assign latch_open = ~external_clock_select_q
	                  | (sck_lvl == clock_edge_select_q);

	ussu_out_latch u_out_latch (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.open_i (latch_open),
		.msb_i  (shift_register_d[7]),
		.bit_o  (latch_bit)
	);

	////////////////////////////////////////////////////////////////////
	// Pin drive. Three-wire uses the push-pull data output; two-wire
	// only ever pulls the data and clock lines low. Unused modes keep
	// all drivers off apart from the clock pin's own port bit.
	// Never driving a one onto a shared line means two devices can
	// never fight over it; the pull-ups make the high level.
	assign data_out_o    = latch_bit;
	assign data_out_oe_o = three_wire & data_out_dir_i;

	assign sda_o    = 1'b0;
	assign sda_oe_o = two_wire & serial_in_dir_i & ~latch_bit;

	// Clock pin: push-pull port bit outside two-wire; open drain and
	// the stretch holds in two-wire, where holds override direction
	assign serial_clock_pin_o = two_wire ? 1'b0 : clock_port_q;
	assign serial_clock_pin_oe_o = two_wire
	                             ? ((clock_dir_i & ~clock_port_q)
	                                | start_hold_q | ovf_hold)
	                             : clock_dir_i;

	////////////////////////////////////////////////////////////////////
	// Status outputs; the overflow and start flags both wake from idle
	// Wake is a level, so it stays up until software clears the flag
	assign shift_register_o        = shift_register_q;
	assign counter_o               = counter_q;
	assign counter_overflow_flag_o = counter_overflow_flag_q;
	assign start_detect_flag_o     = start_detect_flag_q;
	assign wire_mode_o             = wire_mode_q;
	assign idle_wake_o = counter_overflow_flag_q
	                   | start_detect_flag_q;

	// Data input edges are only needed by the start detector
	wire unused_din_rise;
	assign unused_din_rise = din_rise;
endmodule

// ---- src/ussu_map.vh ----
// Constants and bit layout for the universal serial shift unit
`ifndef USSU_MAP_VH
`define USSU_MAP_VH
// Control write field positions
`define USSU_CR_TC      0
`define USSU_CR_CLK     1
`define USSU_CR_CS0     2
`define USSU_CR_CS1     3
`define USSU_CR_WM_LO   4
`define USSU_CR_WM_HI   5
// Status write field positions
`define USSU_SR_SIF     7
`define USSU_SR_OIF     6
`define USSU_SR_CNT_HI  3
// Wire modes
`define USSU_WM_OFF     2'h0
`define USSU_WM_THREE   2'h1
`define USSU_WM_TWO     2'h2
`define USSU_WM_TWO_OVH 2'h3
// Reset values and limits
`define USSU_DATA_RST   8'h00
`define USSU_CNT_RST    4'h0
`define USSU_CNT_MAX    4'hf
`endif

// ---- src/ussu_pin_sync.v ----
// Two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
module ussu_pin_sync (
	// Clock and reset
	input  wire mclk_i,
	input  wire rst_i,
	// Raw pin and conditioned results
	input  wire pin_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// First stage feeds only the second; edges use later stages
	always @(posedge mclk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edge pulses last one system clock
	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q;
	assign fall_o  = ~sync_q & prev_q;
endmodule

// ---- src/ussu_out_latch.v ----
// Output latch between shift register MSB and the data pin
`timescale 1ns/100ps
module ussu_out_latch (
	// Clock and reset
	input  wire mclk_i,
	input  wire rst_i,
	// Latch control and data
	input  wire open_i,
	input  wire msb_i,
	output reg  bit_o
);
	// Follows the MSB while open, holds it while closed
	always @(posedge mclk_i) begin
		if (rst_i) begin
			bit_o <= 1'b0;
		end else if (open_i) begin
			bit_o <= msb_i;
		end
	end
endmodule

// ---- sim/ussu_assertions.sv ----
// Port-level checker for the serial shift unit
`timescale 1ns/100ps
module ussu_assertions (
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       rst_i,
	// Writes
	input wire logic       ctrl_wr_i,
	input wire logic [7:0] ctrl_wdata_i,
	input wire logic       data_wr_i,
	input wire logic [7:0] data_wdata_i,
	input wire logic       status_wr_i,
	input wire logic [7:0] status_wdata_i,
	input wire logic       data_out_dir_i,
	// Observed outputs
	input wire logic [7:0] shift_register_o,
	input wire logic       data_out_oe_o,
	input wire logic       sda_o,
	input wire logic       serial_clock_pin_o,
	input wire logic [3:0] counter_o,
	input wire logic       counter_overflow_flag_o,
	input wire logic [1:0] wire_mode_o,
	input wire logic       idle_wake_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// Strobes, loads and stored fields
	chk_strobe_toggles: assert property (
		ctrl_wr_i && ctrl_wdata_i[0] && !ctrl_wdata_i[5] && !wire_mode_o[1]
		|=> serial_clock_pin_o != $past(serial_clock_pin_o))
		else $error("clock pin did not toggle");
	chk_write_wins: assert property (
		data_wr_i |=> shift_register_o == $past(data_wdata_i))
		else $error("data write lost");
	chk_count_load: assert property (
		status_wr_i |=> counter_o == $past(status_wdata_i[3:0]))
		else $error("counter not loaded");
	chk_flag_clear: assert property (
		status_wr_i && status_wdata_i[6] && counter_o != 4'hf
		|=> !counter_overflow_flag_o)
		else $error("overflow flag not cleared");
	chk_mode_store: assert property (
		ctrl_wr_i |=> wire_mode_o == $past(ctrl_wdata_i[5:4]))
		else $error("wire mode not stored");
	// Counting, wrap and shifting
	chk_wrap_flag: assert property (
		$past(counter_o) == 4'hf && counter_o == 4'h0 && !$past(status_wr_i)
		|-> ##[0:1] counter_overflow_flag_o)
		else $error("wrap did not set overflow");
	chk_count_step: assert property (
		!status_wr_i |=> counter_o == $past(counter_o)
		|| counter_o == $past(counter_o) + 4'h1)
		else $error("counter jumped");
	chk_shift_left: assert property (
		!data_wr_i |=> shift_register_o == $past(shift_register_o)
		|| shift_register_o[7:1] == $past(shift_register_o[6:0]))
		else $error("register moved other than left");
	// Pin drive and wake
	chk_out_enable: assert property (
		data_out_oe_o == (wire_mode_o == 2'h1 && data_out_dir_i))
		else $error("data output enable wrong");
	chk_wake_level: assert property (
		counter_overflow_flag_o |-> idle_wake_o)
		else $error("overflow does not wake");
	chk_two_wire_low: assert property (
		wire_mode_o[1] |-> !serial_clock_pin_o && !sda_o)
		else $error("two-wire line driven high");
endmodule

// ---- sim/ussu_spi_peer.sv ----
// Behavioural SPI master standing across the link from the unit
`timescale 1ns/100ps
module ussu_spi_peer (
	// Frame request
	input  wire logic       start_i,
	input  wire logic       cpha_i,
	input  wire logic [7:0] tx_i,
	// Serial lines
	input  wire logic       miso_i,
	output logic            sck_o,
	output logic            mosi_o,
	// Frame result
	output logic [7:0]      rx_o,
	output logic            busy_o
);
	// Idle: clock parked low, data line parked high
	initial begin
		sck_o = 1'h0;
		mosi_o = 1'h1;
		rx_o = 8'h00;
		busy_o = 1'h0;
	end
	// One byte, MSB first, 400 ns per clock half
	always @(posedge start_i) begin
		busy_o = 1'h1;
		for (int i = 7; i >= 0; i--) begin
			if (!cpha_i)
				mosi_o = tx_i[i];
			#400 sck_o = 1'h1;
			if (cpha_i)
				mosi_o = tx_i[i];
			else
				rx_o[i] = miso_i;
			#400 sck_o = 1'h0;
			if (cpha_i)
				rx_o[i] = miso_i;
		end
		// Hold past the last edge, then go stale so no value is trusted
		#400 mosi_o = ~mosi_o;
		busy_o = 1'h0;
	end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the serial shift unit
`timescale 1ns/100ps
module tb;
	// Design inputs
	logic       mclk_i = 1'h0;
	logic       rst_i = 1'h1;
	logic       ctrl_wr_i = 1'h0, data_wr_i = 1'h0, status_wr_i = 1'h0;
	logic [7:0] ctrl_wdata_i = 8'h00, data_wdata_i = 8'h00;
	logic [7:0] status_wdata_i = 8'h00;
	logic       clk_port_wr_i = 1'h0, clk_port_wdata_i = 1'h0;
	logic       data_out_dir_i = 1'h0, serial_in_dir_i = 1'h0;
	logic       clock_dir_i = 1'h0, timer_match_i = 1'h0;
	// Pins and outputs
	wire        serial_in_pin_i, serial_clock_pin_i;
	wire  [7:0] shift_register_o;
	wire  [3:0] counter_o;
	wire  [1:0] wire_mode_o;
	wire        data_out_o, data_out_oe_o, sda_o, sda_oe_o;
	wire        serial_clock_pin_o, serial_clock_pin_oe_o;
	wire        counter_overflow_flag_o, start_detect_flag_o, idle_wake_o;
	// Peer control and bookkeeping
	logic       go = 1'h0, cpha = 1'h0;
	logic [7:0] tx = 8'h00, d, m;
	wire  [7:0] rx;
	wire        busy;
	wire        peer_sck, peer_mosi;
	logic       tw = 1'h0, scl_m = 1'h1, sda_m = 1'h1;
	int         error_cnt = 0, comparisons = 0;

	always #50 mclk_i = ~mclk_i;

	ussu_core dut (
		.mclk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i, .data_wr_i,
		.data_wdata_i, .shift_register_o, .status_wr_i, .status_wdata_i,
		.clk_port_wr_i, .clk_port_wdata_i, .data_out_dir_i,
		.serial_in_dir_i, .clock_dir_i, .timer_match_i,
		.serial_in_pin_i, .serial_clock_pin_i, .data_out_o,
		.data_out_oe_o, .sda_o, .sda_oe_o, .serial_clock_pin_o,
		.serial_clock_pin_oe_o, .counter_o, .counter_overflow_flag_o,
		.start_detect_flag_o, .wire_mode_o, .idle_wake_o
	);
	ussu_spi_peer peer (
		.start_i(go), .cpha_i(cpha), .tx_i(tx), .miso_i(data_out_o),
		.sck_o(peer_sck), .mosi_o(peer_mosi),
		.rx_o(rx), .busy_o(busy)
	);
	// Two-wire lines idle high through pull-ups; either side pulls low
	assign serial_clock_pin_i = tw ? scl_m & ~(serial_clock_pin_oe_o
	                                           & ~serial_clock_pin_o)
	                               : peer_sck;
	assign serial_in_pin_i = tw ? sda_m & ~(sda_oe_o & ~sda_o) : peer_mosi;
	////////////////////////////////////////////////////////////////////////
	// One write pulse: 0 control, 1 data, 2 status
	task automatic put(input int k, input logic [7:0] v);
		@(negedge mclk_i);
		ctrl_wr_i = (k == 0);
		data_wr_i = (k == 1);
		status_wr_i = (k == 2);
		ctrl_wdata_i = v;
		data_wdata_i = v;
		status_wdata_i = v;
		@(negedge mclk_i);
		{ctrl_wr_i, data_wr_i, status_wr_i} = 3'h0;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(99));
		repeat (8) @(negedge mclk_i);
		rst_i = 1'h0;
		repeat (3) @(negedge mclk_i);
		chk("count rst", 8'h00, {4'h0, counter_o});
		// Master at full rate: toggle, then toggle plus shift
		clock_dir_i = 1'h1;
		data_out_dir_i = 1'h1;
		put(0, 8'h10);
		d = 8'($urandom);
		put(1, d);
		put(2, 8'h4c);
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk_i);
			ctrl_wr_i = 1'h1;
			ctrl_wdata_i = i[0] ? 8'h13 : 8'h11;
		end
		@(negedge mclk_i);
		ctrl_wr_i = 1'h0;
		repeat (2) @(negedge mclk_i);
		chk("pin", 8'h00, {7'h00, serial_clock_pin_o});
		chk("wrap", 8'h00, {4'h0, counter_o});
		chk("ovf", 8'h01, {7'h00, counter_overflow_flag_o});
		chk("shifted", {d[3:0], 4'hf}, shift_register_o);
		// Data write meets a shift strobe in the same cycle
		m = 8'($urandom);
		@(negedge mclk_i);
		{ctrl_wr_i, data_wr_i} = 2'h3;
		data_wdata_i = m;
		@(negedge mclk_i);
		{ctrl_wr_i, data_wr_i} = 2'h0;
		@(negedge mclk_i);
		chk("write wins", m, shift_register_o);
		chk("latch", {7'h00, m[7]}, {7'h00, data_out_o});
		data_out_dir_i = 1'h0;
		@(negedge mclk_i);
		chk("oe off", 8'h00, {7'h00, data_out_oe_o});
		data_out_dir_i = 1'h1;
		// Timer compare as shift clock, counter loaded near the top
		put(0, 8'h14);
		chk("oe on", 8'h01, {7'h00, data_out_oe_o});
		put(2, 8'h4e);
		@(negedge mclk_i);
		timer_match_i = 1'h1;
		repeat (2) @(negedge mclk_i);
		timer_match_i = 1'h0;
		@(negedge mclk_i);
		chk("timer count", 8'h00, {4'h0, counter_o});
		chk("timer ovf", 8'h01, {7'h00, counter_overflow_flag_o});
		chk("timer shift", {m[5:0], 2'h3}, shift_register_o);
		// Port write clears the clock pin; the last toggle left it high
		clk_port_wdata_i = 1'h0;
		clk_port_wr_i = 1'h1;
		@(negedge mclk_i);
		clk_port_wr_i = 1'h0;
		@(negedge mclk_i);
		chk("port", 8'h00, {7'h00, serial_clock_pin_o});
		chk("sck oe", 8'h01, {7'h00, serial_clock_pin_oe_o});
		// Slave exchanges in data modes 0 and 1, corner bytes first
		clock_dir_i = 1'h0;
		for (int k = 0; k < 6; k++) begin
			cpha = k[0];
			put(0, cpha ? 8'h1c : 8'h18);
			put(2, 8'h40);
			d = (k == 0) ? 8'h80 : 8'($urandom);
			tx = (k == 1) ? 8'h01 : 8'($urandom);
			put(1, d);
			go = 1'h1;
			@(negedge mclk_i);
			go = 1'h0;
			for (int n = 0; n < 120 && (busy || !counter_overflow_flag_o); n++)
				@(negedge mclk_i);
			if (busy || !counter_overflow_flag_o) begin
				error_cnt++;
				$display("BAD transfer expected done seen timeout");
				give_verdict();
			end
			chk("slave rx", tx, shift_register_o);
			chk("peer rx", d, rx);
			chk("edges", 8'h00, {4'h0, counter_o});
			chk("wake", 8'h01, {7'h00, idle_wake_o});
		end
		// Two-wire: the bench is the master on open-drain lines
		tw = 1'h1;
		repeat (4) @(negedge mclk_i);
		put(0, 8'h28);
		chk("scl", 8'h00, {7'h00, serial_clock_pin_o});
		put(2, 8'hc0);
		sda_m = 1'h0;
		repeat (4) @(negedge mclk_i);
		chk("start", 8'h01, {7'h00, start_detect_flag_o});
		chk("start wake", 8'h01, {7'h00, idle_wake_o});
		scl_m = 1'h0;
		repeat (4) @(negedge mclk_i);
		chk("hold", 8'h01, {7'h00, serial_clock_pin_oe_o});
		serial_in_dir_i = 1'h1;
		put(1, 8'h00);
		chk("sda oe", 8'h01, {7'h00, sda_oe_o});
		serial_in_dir_i = 1'h0;
		scl_m = 1'h1;
		repeat (4) @(negedge mclk_i);
		chk("scl held", 8'h00, {7'h00, serial_clock_pin_i});
		put(2, 8'h80);
		repeat (2) @(negedge mclk_i);
		chk("scl free", 8'h01, {7'h00, serial_clock_pin_i});
		chk("start clr", 8'h00, {7'h00, start_detect_flag_o});
		give_verdict();
	end
endmodule

bind ussu_core ussu_assertions u_chk (
	.mclk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i, .data_wr_i, .data_wdata_i,
	.status_wr_i, .status_wdata_i, .data_out_dir_i, .shift_register_o,
	.data_out_oe_o, .sda_o, .serial_clock_pin_o, .counter_o,
	.counter_overflow_flag_o, .wire_mode_o, .idle_wake_o
);
